// ===== pll_ratio_consts.svh
`ifndef PLL_RATIO_CONSTS_SVH
`define PLL_RATIO_CONSTS_SVH

// register indices; the byte address is four times the index
`define IDX_A_FRACTION_LOW     7'h00
`define IDX_A_FRACTION_MID     7'h01
`define IDX_A_INTEGER_FRAC_HI  7'h02
`define IDX_A_DIVIDER_CONTROL  7'h03
`define IDX_B_FRACTION_LOW     7'h04
`define IDX_B_FRACTION_MID     7'h05
`define IDX_B_INTEGER_FRAC_HI  7'h06
`define IDX_B_DIVIDER_CONTROL  7'h07
`define IDX_READBACK_CONTROL   7'h34
`define IDX_SYNTH_MODE         7'h40
`define IDX_SYNTH_STATUS       7'h41
`define IDX_W                  7

// reset values
`define RST_FRACTION_LOW       9'h121
`define RST_FRACTION_MID       9'h17E
`define RST_INTEGER_FRAC_HI    9'h07D
`define RST_A_DIVIDER_CONTROL  9'h014
`define RST_B_DIVIDER_CONTROL  9'h194
`define RST_READBACK_CONTROL   9'h000

// field positions
`define FLD_FRAC_HI_MSB        3
`define FLD_INTEGER_MSB        7
`define FLD_INTEGER_LSB        4
`define FLD_INPUT_HALVE        0
`define FLD_OUTPUT_HALVE       1
`define FLD_OUT_DIV_MSB        4
`define FLD_OUT_DIV_LSB        3
`define FLD_READMUX_MSB        2
`define FLD_CONT_READBACK      3
`define FLD_READ_ENABLE        4
`define FLD_SPDIF_RX_MODE      0

// timing: registered wishbone answer
`define ACK_LATENCY_CYCLES     1

`endif

// ===== pll_ratio_pkg.sv
package pll_ratio_pkg;

  typedef logic [8:0] reg9_t;

  typedef struct packed {
    logic [3:0]  integer_part;
    logic [21:0] fraction;
    logic        input_halve;
    logic        output_halve;
    logic [1:0]  output_divider;
  } synth_cfg_t;

  // ratio is 4.22 fixed point; osc_ratio is relative to the oscillator, 4.23
  typedef struct packed {
    logic [25:0] ratio;
    logic [26:0] osc_ratio;
    logic        output_halve;
    logic [1:0]  output_divider;
    logic [2:0]  out_div_code;
  } synth_eff_t;

endpackage : pll_ratio_pkg

// ===== synth_ratio_unit.sv
`timescale 1ns/1ps
module synth_ratio_unit #(
  parameter bit PRIMARY = 1'b1
) (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire pll_ratio_pkg::synth_cfg_t cfg,
  input  wire logic                     spdif_rx_mode,
  input  wire logic [1:0]               auto_divider,
  output pll_ratio_pkg::synth_eff_t     eff
);
  import pll_ratio_pkg::*;

  synth_eff_t eff_d;
  synth_eff_t eff_q;

  always_comb
  begin
    eff_d.ratio = {cfg.integer_part, cfg.fraction};
    // halving the input halves the ratio seen from the oscillator
    eff_d.osc_ratio = cfg.input_halve ? {1'b0, eff_d.ratio}
                                      : {eff_d.ratio, 1'b0};
    if (spdif_rx_mode)
    begin
      // receiver mode: only the primary synthesiser has a divided output
      eff_d.output_halve   = PRIMARY ? cfg.output_halve : 1'b0;
      eff_d.output_divider = PRIMARY ? auto_divider : 2'b00;
    end
    else
    begin
      eff_d.output_halve   = cfg.output_halve;
      eff_d.output_divider = cfg.output_divider;
    end
    eff_d.out_div_code = {eff_d.output_divider, eff_d.output_halve};
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      eff_q <= '0;
    else
      eff_q <= eff_d;
  end

  assign eff = eff_q;

endmodule : synth_ratio_unit

// ===== pll_ratio_config_regs.sv
// Summary of operation
// - synth A fraction is 22 bits: regs 0, 1 and low nibble of 2.
// - reads of registers 0 and 1 return identification, not the fraction.
// - identification readback is suppressed while continuous readback is set.
// - reads of register 2 return the revision number.
// - register 3 bit 0 halves the oscillator before synth A.
// - receiver mode: bit 1 picks 256fs or 128fs; synth B halve ignored.
// - synth A divider resets to 10; automatic in receiver mode; B's ignored.
// - user mode: divider select and halve bit together set final output.
// - synth B fraction assembled likewise; low part resets to 100100001.
//
// Design decision made here: the Wishbone slave port.
`include "pll_ratio_consts.svh"
`timescale 1ns/1ps
module pll_ratio_config_regs #(
  parameter int         ADDR_W    = 12,
  parameter logic [8:0] DEVICE_ID0 = 9'h0A5, // arbitrary value
  parameter logic [8:0] DEVICE_ID1 = 9'h05A, // arbitrary value
  parameter logic [8:0] REVISION   = 9'h003  // arbitrary value
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [ADDR_W-1:0]         wb_adr_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic [31:0]                    wb_dat_o,
  input  wire logic                      wb_we_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  output logic                           wb_ack_o,
  input  wire logic [1:0]                spdif_auto_divider,
  output logic                           spdif_rx_mode,
  output logic                           continuous_readback_flag,
  output pll_ratio_pkg::synth_cfg_t      synth_a_cfg,
  output pll_ratio_pkg::synth_cfg_t      synth_b_cfg,
  output pll_ratio_pkg::synth_eff_t      synth_a_eff,
  output pll_ratio_pkg::synth_eff_t      synth_b_eff
);
  import pll_ratio_pkg::*;

  if (ADDR_W < `IDX_W + 2)
  begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  function automatic logic [`IDX_W-1:0] reg_index(input logic [ADDR_W-1:0] adr);
    reg_index = adr[`IDX_W+1:2];
  endfunction : reg_index

  function automatic logic addr_in_range(input logic [ADDR_W-1:0] adr);
    logic ok;
    ok = (adr[1:0] == 2'b00);
    if (ADDR_W > `IDX_W + 2)
      ok = ok && ((adr >> (`IDX_W + 2)) == '0);
    addr_in_range = ok;
  endfunction : addr_in_range

  function automatic reg9_t synth_reset(input int i);
    case (i)
      0, 4:    synth_reset = `RST_FRACTION_LOW;
      1, 5:    synth_reset = `RST_FRACTION_MID;
      2, 6:    synth_reset = `RST_INTEGER_FRAC_HI;
      3:       synth_reset = `RST_A_DIVIDER_CONTROL;
      default: synth_reset = `RST_B_DIVIDER_CONTROL;
    endcase
  endfunction : synth_reset

  function automatic synth_cfg_t assemble(input reg9_t lo, input reg9_t mid,
                                          input reg9_t hi, input reg9_t ctl);
    synth_cfg_t c;
    c.fraction       = {hi[`FLD_FRAC_HI_MSB:0], mid, lo};
    c.integer_part   = hi[`FLD_INTEGER_MSB:`FLD_INTEGER_LSB];
    c.input_halve    = ctl[`FLD_INPUT_HALVE];
    c.output_halve   = ctl[`FLD_OUTPUT_HALVE];
    c.output_divider = ctl[`FLD_OUT_DIV_MSB:`FLD_OUT_DIV_LSB];
    assemble = c;
  endfunction : assemble

  reg9_t                synth_q [0:7];
  reg9_t                readback_q;
  logic                 mode_q;
  logic                 ack_q;
  logic [31:0]          dat_q;
  logic                 req;
  logic                 wr_en;
  logic [`IDX_W-1:0]    idx;
  logic                 in_range;
  reg9_t                wr_val;
  reg9_t                rd_d;

  assign req      = wb_cyc_i && wb_stb_i;
  assign idx      = reg_index(wb_adr_i);
  assign in_range = addr_in_range(wb_adr_i);
  // the write lands on the edge at which the master samples ack
  assign wr_en    = req && wb_we_i && ack_q && in_range;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      ack_q <= 1'b0;
    else
      ack_q <= req && !ack_q;
  end

  function automatic reg9_t merge(input reg9_t old, input logic [31:0] d,
                                  input logic [3:0] sel);
    reg9_t m;
    m[7:0] = sel[0] ? d[7:0] : old[7:0];
    m[8]   = sel[1] ? d[8] : old[8];
    merge = m;
  endfunction : merge

  assign wr_val = merge(synth_q[idx[2:0]], wb_dat_i, wb_sel_i);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < 8; i++)
        synth_q[i] <= synth_reset(i);
    end
    else if (wr_en && idx < 7'h08)
      synth_q[idx[2:0]] <= wr_val;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      readback_q <= `RST_READBACK_CONTROL;
    else if (wr_en && idx == `IDX_READBACK_CONTROL)
      readback_q <= merge(readback_q, wb_dat_i, wb_sel_i) & 9'h01F;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      mode_q <= 1'b0;
    else if (wr_en && idx == `IDX_SYNTH_MODE && wb_sel_i[0])
      mode_q <= wb_dat_i[`FLD_SPDIF_RX_MODE];
  end

  // read mux; the fraction bits written at 0 and 1 read back only in continuous readback, those at 2 never
  always_comb
  begin
    rd_d = '0;
    if (in_range)
    begin
      case (idx)
        `IDX_A_FRACTION_LOW:
          rd_d = continuous_readback_flag ? synth_q[0] : DEVICE_ID0;
        `IDX_A_FRACTION_MID:
          rd_d = continuous_readback_flag ? synth_q[1] : DEVICE_ID1;
        `IDX_A_INTEGER_FRAC_HI:
          rd_d = REVISION;
        `IDX_A_DIVIDER_CONTROL,
        `IDX_B_FRACTION_LOW,
        `IDX_B_FRACTION_MID,
        `IDX_B_INTEGER_FRAC_HI,
        `IDX_B_DIVIDER_CONTROL:
          rd_d = synth_q[idx[2:0]];
        `IDX_READBACK_CONTROL:
          rd_d = readback_q;
        `IDX_SYNTH_MODE:
          rd_d = {8'h00, mode_q};
        `IDX_SYNTH_STATUS:
          rd_d = {2'b00, synth_b_eff.out_div_code, synth_a_eff.out_div_code, mode_q};
        default:
          rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      dat_q <= '0;
    else if (req && !ack_q && !wb_we_i)
      dat_q <= {23'h000000, rd_d};
  end

  assign wb_ack_o                 = ack_q;
  assign wb_dat_o                 = dat_q;
  assign spdif_rx_mode            = mode_q;
  assign continuous_readback_flag = readback_q[`FLD_CONT_READBACK];
  assign synth_a_cfg = assemble(synth_q[0], synth_q[1], synth_q[2], synth_q[3]);
  assign synth_b_cfg = assemble(synth_q[4], synth_q[5], synth_q[6], synth_q[7]);

  // input halve bits are taken as programmed; software keeps them equal in
  // receiver mode and keeps the integer in range, nothing here enforces it
  synth_ratio_unit #(
    .PRIMARY (1'b1)
  ) u_synth_a (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .cfg           (synth_a_cfg),
    .spdif_rx_mode (mode_q),
    .auto_divider  (spdif_auto_divider),
    .eff           (synth_a_eff)
  );

  synth_ratio_unit #(
    .PRIMARY (1'b0)
  ) u_synth_b (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .cfg           (synth_b_cfg),
    .spdif_rx_mode (mode_q),
    .auto_divider  (spdif_auto_divider),
    .eff           (synth_b_eff)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  logic rd_take;
  assign rd_take = req && !ack_q && !wb_we_i && in_range;

  AST_A_FRACTION_ASSEMBLY: assert property (
    synth_a_cfg.fraction == {synth_q[2][3:0], synth_q[1], synth_q[0]})
    else $error("synth A fraction mis-assembled");

  AST_ID_LOW_READ: assert property (
    rd_take && idx == `IDX_A_FRACTION_LOW && !continuous_readback_flag
    |=> wb_ack_o && wb_dat_o == {23'h000000, DEVICE_ID0})
    else $error("identification not returned at index 0");

  AST_ID_MID_READ: assert property (
    rd_take && idx == `IDX_A_FRACTION_MID && !continuous_readback_flag
    |=> wb_dat_o[8:0] == DEVICE_ID1)
    else $error("identification not returned at index 1");

  AST_ID_SUPPRESSED: assert property (
    rd_take && idx == `IDX_A_FRACTION_LOW && continuous_readback_flag
    |=> wb_dat_o[8:0] == $past(synth_q[0]))
    else $error("identification returned in continuous readback");

  AST_REVISION_READ: assert property (
    rd_take && idx == `IDX_A_INTEGER_FRAC_HI |=> wb_dat_o[8:0] == REVISION)
    else $error("revision not returned at index 2");

  AST_INPUT_HALVE: assert property (
    synth_a_cfg.input_halve ##1 synth_a_cfg.input_halve
    |-> synth_a_eff.osc_ratio == {1'b0, synth_a_eff.ratio})
    else $error("input halve not applied to synth A");

  AST_SPDIF_HALVE: assert property (
    mode_q |=> synth_b_eff.output_halve == 1'b0
               && synth_a_eff.output_halve == $past(synth_a_cfg.output_halve))
    else $error("receiver mode halve selection wrong");

  AST_SPDIF_DIVIDER: assert property (
    mode_q |=> synth_a_eff.output_divider == $past(spdif_auto_divider)
               && synth_b_eff.output_divider == 2'b00)
    else $error("receiver mode divider not automatic");

  AST_USER_DIVIDER: assert property (
    !mode_q && !$past(sys_rst) |=> synth_b_eff.out_div_code
                == {$past(synth_b_cfg.output_divider), $past(synth_b_cfg.output_halve)})
    else $error("user mode divider code wrong");

  AST_B_FRACTION_ASSEMBLY: assert property (
    synth_b_cfg.fraction == {synth_q[6][3:0], synth_q[5], synth_q[4]})
    else $error("synth B fraction mis-assembled");

  // eff is cleared in reset and lags cfg by one edge, so the edge after release is skipped
  AST_RATIO: assert property (
    !$past(sys_rst)
    |=> synth_a_eff.ratio == $past({synth_a_cfg.integer_part, synth_a_cfg.fraction}))
    else $error("synth A ratio wrong");

  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  AST_ACK_LATENCY: assert property (
    req && !ack_q |=> wb_ack_o)
    else $error("request not answered in the next cycle");

  AST_ACK_IDLE: assert property (
    !req |=> !wb_ack_o)
    else $error("ack without a request");

  AST_DATA_UPPER_ZERO: assert property (
    wb_dat_o[31:9] == 23'h000000)
    else $error("read data upper bits not zero");

  AST_UNMAPPED_READ: assert property (
    rd_take && idx == 7'h10 |=> wb_dat_o == 32'h00000000)
    else $error("unmapped read returned data");

  AST_ID_MID_SUPPRESSED: assert property (
    rd_take && idx == `IDX_A_FRACTION_MID && continuous_readback_flag
    |=> wb_dat_o[8:0] == $past(synth_q[1]))
    else $error("identification returned at index 1 in continuous readback");

  AST_A_DIVIDER_WRITE: assert property (
    wr_en && idx == `IDX_A_DIVIDER_CONTROL |=> synth_q[3] == $past(wr_val))
    else $error("synth A divider control write lost");

  AST_B_LOW_WRITE: assert property (
    wr_en && idx == `IDX_B_FRACTION_LOW |=> synth_q[4] == $past(wr_val))
    else $error("synth B fraction low write lost");

  AST_MODE_WRITE: assert property (
    wr_en && idx == `IDX_SYNTH_MODE && wb_sel_i[0]
    |=> mode_q == $past(wb_dat_i[`FLD_SPDIF_RX_MODE]))
    else $error("receiver mode write lost");

  AST_STATUS_READ_ONLY: assert property (
    wr_en && idx == `IDX_SYNTH_STATUS |=> $stable(mode_q) && $stable(readback_q))
    else $error("status write changed state");

  AST_READBACK_UNUSED_ZERO: assert property (
    readback_q[8:5] == 4'h0)
    else $error("unused readback bits set");

  AST_INPUT_FULL: assert property (
    !synth_a_cfg.input_halve ##1 !synth_a_cfg.input_halve
    |-> synth_a_eff.osc_ratio == {synth_a_eff.ratio, 1'b0})
    else $error("undivided input not applied to synth A");

  AST_A_USER_DIVIDER: assert property (
    !mode_q && !$past(sys_rst)
    |=> synth_a_eff.out_div_code
        == {$past(synth_a_cfg.output_divider), $past(synth_a_cfg.output_halve)})
    else $error("user mode divider code wrong for synth A");

  AST_B_RATIO: assert property (
    !$past(sys_rst)
    |=> synth_b_eff.ratio == $past({synth_b_cfg.integer_part, synth_b_cfg.fraction}))
    else $error("synth B ratio wrong");

  COV_ID_READ: cover property (
    rd_take && idx == `IDX_A_FRACTION_LOW && !continuous_readback_flag);
  COV_SPDIF_MODE: cover property (
    mode_q && spdif_auto_divider != 2'b00);
  COV_A_WRITE: cover property (
    wr_en && idx == `IDX_A_DIVIDER_CONTROL);
  COV_CONT_READ: cover property (
    rd_take && idx == `IDX_A_FRACTION_MID && continuous_readback_flag);
  COV_STATUS_READ: cover property (
    rd_take && idx == `IDX_SYNTH_STATUS && mode_q);

endmodule : pll_ratio_config_regs

// ===== pll_ratio_config_regs_test.sv
`timescale 1ns/1ps
module pll_ratio_config_regs_test;
  import pll_ratio_pkg::*;
  localparam logic [8:0] ID0 = 9'h0C3; // arbitrary value
  localparam logic [8:0] ID1 = 9'h13C; // arbitrary value
  localparam logic [8:0] REV = 9'h006; // arbitrary value

  logic        clk;
  logic        sys_rst;
  logic [11:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_we_i;
  logic [3:0]  wb_sel_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_ack_o;
  logic [1:0]  spdif_auto_divider;
  logic        spdif_rx_mode;
  logic        continuous_readback_flag;
  synth_cfg_t  synth_a_cfg;
  synth_cfg_t  synth_b_cfg;
  synth_eff_t  synth_a_eff;
  synth_eff_t  synth_b_eff;
  reg9_t       regs [0:7];
  logic        cont;
  logic        mode;
  reg9_t       rb;
  int          errors;
  int          cmp_count;

  pll_ratio_config_regs #(.DEVICE_ID0(ID0), .DEVICE_ID1(ID1), .REVISION(REV)) uut (
    .clk                      (clk),
    .sys_rst                  (sys_rst),
    .wb_adr_i                 (wb_adr_i),
    .wb_dat_i                 (wb_dat_i),
    .wb_dat_o                 (wb_dat_o),
    .wb_we_i                  (wb_we_i),
    .wb_sel_i                 (wb_sel_i),
    .wb_cyc_i                 (wb_cyc_i),
    .wb_stb_i                 (wb_stb_i),
    .wb_ack_o                 (wb_ack_o),
    .spdif_auto_divider       (spdif_auto_divider),
    .spdif_rx_mode            (spdif_rx_mode),
    .continuous_readback_flag (continuous_readback_flag),
    .synth_a_cfg              (synth_a_cfg),
    .synth_b_cfg              (synth_b_cfg),
    .synth_a_eff              (synth_a_eff),
    .synth_b_eff              (synth_b_eff)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // one classic cycle; called just after a rising edge
  task automatic wb(input logic [6:0] idx, input logic we, input reg9_t wd,
                    output logic [31:0] rd);
    wb_adr_i <= {3'h0, idx, 2'h0};
    wb_dat_i <= {23'h0, wd};
    wb_we_i  <= we;
    wb_sel_i <= 4'h3;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    // ack and read data are taken at the rising edge that samples ack high
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic wr(input logic [6:0] idx, input reg9_t wd);
    logic [31:0] rd;
    wb(idx, 1'b1, wd, rd);
    if (idx < 7'h08)
      regs[idx[2:0]] = wd;
  endtask : wr

  task automatic load_reset_model;
    cont = 1'b0;
    mode = 1'b0;
    rb   = 9'h000;
    regs = '{9'h121, 9'h17E, 9'h07D, 9'h014, 9'h121, 9'h17E, 9'h07D, 9'h194};
  endtask : load_reset_model

  function automatic synth_cfg_t exp_cfg(input int b);
    synth_cfg_t c;
    c.fraction       = {regs[b+2][3:0], regs[b+1], regs[b]};
    c.integer_part   = regs[b+2][7:4];
    c.input_halve    = regs[b+3][0];
    c.output_halve   = regs[b+3][1];
    c.output_divider = regs[b+3][4:3];
    return c;
  endfunction : exp_cfg

  function automatic synth_eff_t exp_eff(input synth_cfg_t c, input logic prim);
    synth_eff_t e;
    e.ratio          = {c.integer_part, c.fraction};
    e.osc_ratio      = c.input_halve ? {1'b0, e.ratio} : {e.ratio, 1'b0};
    e.output_halve   = (mode && !prim) ? 1'b0 : c.output_halve;
    e.output_divider = mode ? (prim ? spdif_auto_divider : 2'h0) : c.output_divider;
    e.out_div_code   = {e.output_divider, e.output_halve};
    return e;
  endfunction : exp_eff

  function automatic logic [31:0] exp_rd(input logic [6:0] idx);
    synth_eff_t a;
    synth_eff_t b;
    a = exp_eff(exp_cfg(0), 1'b1);
    b = exp_eff(exp_cfg(4), 1'b0);
    if (idx < 7'h02 && !cont)
      return (idx == 7'h00) ? {23'h0, ID0} : {23'h0, ID1};
    if (idx == 7'h02)
      return {23'h0, REV};
    if (idx < 7'h08)
      return {23'h0, regs[idx[2:0]]};
    if (idx == 7'h34)
      return {23'h0, rb};
    if (idx == 7'h40)
      return {31'h0, mode};
    if (idx == 7'h41)
      return {23'h0, 2'h0, b.out_div_code, a.out_div_code, mode};
    return 32'h0;
  endfunction : exp_rd

  task automatic check_all;
    logic [31:0] rd;
    logic [6:0]  idx;
    repeat (2) @(negedge clk);
    chk(64'(synth_a_cfg), 64'(exp_cfg(0)));
    chk(64'(synth_b_cfg), 64'(exp_cfg(4)));
    chk(64'(synth_a_eff), 64'(exp_eff(exp_cfg(0), 1'b1)));
    chk(64'(synth_b_eff), 64'(exp_eff(exp_cfg(4), 1'b0)));
    chk({62'h0, spdif_rx_mode, continuous_readback_flag}, {62'h0, mode, cont});
    @(posedge clk);
    for (int i = 0; i < 12; i++)
    begin
      case (i)
        8:       idx = 7'h10;
        9:       idx = 7'h34;
        10:      idx = 7'h40;
        11:      idx = 7'h41;
        default: idx = 7'(i);
      endcase
      wb(idx, 1'b0, 9'h000, rd);
      chk({32'h0, rd}, {32'h0, exp_rd(idx)});
    end
  endtask : check_all

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end

  initial
  begin
    reg9_t d;
    errors = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    wb_adr_i = 12'h000;
    wb_dat_i = 32'h0;
    wb_we_i = 1'b0;
    wb_sel_i = 4'h0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    spdif_auto_divider = 2'h0;
    load_reset_model();
    void'($urandom(32'hf0afcd59));
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    check_all();
    // rounds walk every pairing of receiver mode and continuous readback
    for (int r = 0; r < 8; r++)
    begin
      spdif_auto_divider <= 2'($urandom);
      for (int i = 0; i < 8; i++)
      begin
        d = 9'($urandom);
        if (i[1:0] == 2'd2)
          d[7:4] = 4'(5 + $urandom % 9);
        if (i == 7 && r[1])
          d[0] = regs[3][0];
        wr(7'(i), d);
      end
      cont = r[0];
      mode = r[1];
      d = 9'($urandom);
      d[3] = cont;
      rb = d & 9'h01F;
      wr(7'h34, d);
      wr(7'h40, {8'h0, mode});
      wr(7'h10, 9'h1FF);
      // status is read only: this write must leave mode and readback alone
      wr(7'h41, 9'h1FF);
      check_all();
    end
    // a second reset in mid-run must bring back every reset value
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    load_reset_model();
    check_all();
    summarize();
  end
endmodule : pll_ratio_config_regs_test
